//--- gcs_pkg.sv
// Behaviour
// RULE_01: Pin A asserts on overtemp prewarning (external).
// RULE_02: Pin A asserts on motor stall (external).
// RULE_03: Internal: pin A interrupt or half-rate step.
// RULE_04: Pin B asserts on motor stall (external).
// RULE_05: Internal: pin B compare or direction.
// RULE_06: Pin B asserts at table position zero.
// RULE_07: Pin B asserts while second-half chopper on.
// RULE_08: Pin B toggles on each skipped step.
// RULE_09: Bit 12 selects pin A drive style.
// RULE_10: Bit 13 selects pin B drive style.
// RULE_11: Hysteresis one sixteenth or one thirty-second.
// RULE_12: Bit 15 lets halt input stop sequencer.
// RULE_13: Bit 16 enables direct coil current mode.
// RULE_14: Bit 17 drives analog probe output.
// RULE_15: Writing one clears a status flag.
// RULE_16: Reset flag set after device reset.
// RULE_17: Driver error flag; clear needs cool temperature.
// RULE_18: Pump undervoltage latched; driver disabled meanwhile.
// RULE_19: Counter counts successful serial writes only.
// RULE_20: Counter wraps from maximum to zero.
// RULE_21: Counter idle in SPI operation.
// RULE_22: External step source input readable.
package gcs_pkg;
    // ==========================================
    // Register map
    localparam logic [6:0] ADDR_GLOBAL_CONFIG = 7'h00;
    localparam logic [6:0] ADDR_GLOBAL_STATUS = 7'h01;
    localparam logic [6:0] ADDR_SERIAL_WRITE_COUNTER = 7'h02;
    localparam logic [6:0] ADDR_INPUT_STATE = 7'h04;
    localparam int CONFIG_WIDTH = 18;
    localparam logic [17:0] CONFIG_RESET = 18'h00000;
    localparam logic [2:0] STATUS_RESET = 3'h1;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    // ==========================================
    // Field positions
    localparam int BIT_A_OVERTEMP = 6;
    localparam int BIT_A_BLOCK_STEP = 7;
    localparam int BIT_B_BLOCK_DIR = 8;
    localparam int BIT_B_TABLE_ZERO = 9;
    localparam int BIT_B_CHOPPER_ON = 10;
    localparam int BIT_B_SKIP = 11;
    localparam int BIT_A_PUSH_PULL = 12;
    localparam int BIT_B_PUSH_PULL = 13;
    localparam int BIT_SMALL_HYST = 14;
    localparam int BIT_STOP_ENABLE = 15;
    localparam int BIT_DIRECT_MODE = 16;
    localparam int BIT_TEST_MODE = 17;
    localparam int STAT_RESET = 0;
    localparam int STAT_DRV_ERR = 1;
    localparam int STAT_UNDERVOLT = 2;
    localparam int INPUT_SRC_BIT = 6;
endpackage : gcs_pkg

//--- global_config_status_regs.sv
`timescale 1ns/1ps
module global_config_status_regs
    import gcs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [6:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic uart_mode,
    output logic [31:0] rd_data,
    input wire logic external_step_source_sel,
    input wire logic halt_request_pin,
    input wire logic overtemp_warn,
    input wire logic motor_block,
    input wire logic table_zero,
    input wire logic chopper_on_second_half,
    input wire logic lost_step_inc,
    input wire logic driver_fault,
    input wire logic overtemp_active,
    input wire logic pump_undervolt,
    input wire logic ramp_interrupt,
    input wire logic ramp_step,
    input wire logic ramp_dir,
    input wire logic position_compare,
    output logic alert_pin_a_pad_o,
    output logic alert_pin_a_pad_oe,
    output logic alert_pin_b_pad_o,
    output logic alert_pin_b_pad_oe,
    output logic small_hysteresis,
    output logic sequencer_halt,
    output logic direct_coil_mode,
    output logic probe_output_test_en,
    output logic driver_disable
);
    import gcs_pkg::*;

    // ==========================================
    // Pin synchronisers (3 stages, stable when last two agree)
    logic [2:0] src_sync_reg, src_sync_next;
    logic [2:0] halt_sync_reg, halt_sync_next;
    logic src_reg, src_next;
    logic halt_reg, halt_next;

    // Next values for synchronisers
    always_comb begin
        src_sync_next = {src_sync_reg[1:0], external_step_source_sel};
        halt_sync_next = {halt_sync_reg[1:0], halt_request_pin};
        src_next = (src_sync_reg[2] == src_sync_reg[1]) ? src_sync_reg[2] : src_reg;
        halt_next = (halt_sync_reg[2] == halt_sync_reg[1]) ? halt_sync_reg[2] : halt_reg;
    end

    // Register synchronisers
    always_ff @(posedge clk) begin
        if (reset) begin
            src_sync_reg <= 3'h0;
            halt_sync_reg <= 3'h0;
            src_reg <= 1'b0;
            halt_reg <= 1'b0;
        end else if (clk_en) begin
            src_sync_reg <= src_sync_next;
            halt_sync_reg <= halt_sync_next;
            src_reg <= src_next;
            halt_reg <= halt_next;
        end
    end

    // ==========================================
    // Register file
    logic [17:0] config_reg, config_next;
    logic [2:0] status_reg, status_next;
    logic [7:0] counter_reg, counter_next;
    logic [31:0] rd_data_next;
    logic [2:0] clear_req;
    logic [2:0] set_req;

    // Writes, W1C flags and the write counter; set beats clear
    always_comb begin
        config_next = config_reg;
        counter_next = counter_reg;
        clear_req = 3'h0;
        if (wr_en && addr == ADDR_GLOBAL_CONFIG)
            config_next = wr_data[CONFIG_WIDTH-1:0];
        if (wr_en && addr == ADDR_GLOBAL_STATUS)
            clear_req = wr_data[2:0]; // [RULE_15]
        // Drv_err clear only with temperature back below limit
        if (overtemp_active)
            clear_req[STAT_DRV_ERR] = 1'b0; // [RULE_17]
        set_req = 3'h0;
        set_req[STAT_DRV_ERR] = driver_fault; // [RULE_17]
        set_req[STAT_UNDERVOLT] = pump_undervolt; // [RULE_18]
        status_next = (status_reg & ~clear_req) | set_req;
        // SPI writes are not counted; wraps naturally
        if (wr_en && uart_mode)
            counter_next = counter_reg + 8'h01; // [RULE_19] [RULE_20] [RULE_21]
        rd_data_next = 32'h0;
        case (addr)
            ADDR_GLOBAL_CONFIG: rd_data_next = {14'h0, config_reg};
            ADDR_GLOBAL_STATUS: rd_data_next = {29'h0, status_reg};
            ADDR_SERIAL_WRITE_COUNTER: rd_data_next = {24'h0, counter_reg};
            ADDR_INPUT_STATE: rd_data_next[INPUT_SRC_BIT] = src_reg; // [RULE_22]
            default: rd_data_next = 32'h0;
        endcase
        if (!rd_en)
            rd_data_next = rd_data;
    end

    // Register storage; reset flag comes up set
    always_ff @(posedge clk) begin
        if (reset) begin
            config_reg <= CONFIG_RESET;
            status_reg <= STATUS_RESET; // [RULE_16]
            counter_reg <= COUNTER_RESET;
            rd_data <= 32'h0;
        end else if (clk_en) begin
            config_reg <= config_next;
            status_reg <= status_next;
            counter_reg <= counter_next;
            rd_data <= rd_data_next;
        end
    end

    // ==========================================
    // Alert pin routing
    logic step_half_reg, step_half_next;
    logic skip_tgl_reg, skip_tgl_next;
    logic a_act, b_act;
    logic a_o_next, a_oe_next, b_o_next, b_oe_next;
    logic hyst_next, halt_out_next, direct_next, test_next, drv_dis_next;

    // Active levels and drive style for both alert pins
    always_comb begin
        step_half_next = step_half_reg ^ ramp_step; // Both edges carry steps
        skip_tgl_next = skip_tgl_reg ^ (lost_step_inc & config_reg[BIT_B_SKIP]); // [RULE_08]
        if (src_reg) begin
            a_act = (config_reg[BIT_A_OVERTEMP] & overtemp_warn) // [RULE_01]
                  | (config_reg[BIT_A_BLOCK_STEP] & motor_block); // [RULE_02]
            b_act = (config_reg[BIT_B_BLOCK_DIR] & motor_block) // [RULE_04]
                  | (config_reg[BIT_B_TABLE_ZERO] & table_zero) // [RULE_06]
                  | (config_reg[BIT_B_CHOPPER_ON] & chopper_on_second_half) // [RULE_07]
                  | skip_tgl_reg; // [RULE_08]
        end else begin
            a_act = config_reg[BIT_A_BLOCK_STEP] ? step_half_reg : ramp_interrupt; // [RULE_03]
            b_act = config_reg[BIT_B_BLOCK_DIR] ? ramp_dir : position_compare; // [RULE_05]
        end
        // Open collector pulls low only; push-pull always drives
        if (config_reg[BIT_A_PUSH_PULL]) begin // [RULE_09]
            a_o_next = a_act;
            a_oe_next = 1'b1;
        end else begin
            a_o_next = 1'b0;
            a_oe_next = a_act;
        end
        if (config_reg[BIT_B_PUSH_PULL]) begin // [RULE_10]
            b_o_next = b_act;
            b_oe_next = 1'b1;
        end else begin
            b_o_next = 1'b0;
            b_oe_next = b_act;
        end
        hyst_next = config_reg[BIT_SMALL_HYST]; // [RULE_11]
        halt_out_next = config_reg[BIT_STOP_ENABLE] & halt_reg; // [RULE_12]
        direct_next = config_reg[BIT_DIRECT_MODE]; // [RULE_13]
        test_next = config_reg[BIT_TEST_MODE]; // [RULE_14]
        drv_dis_next = pump_undervolt; // [RULE_18]
    end

    // Output registers
    always_ff @(posedge clk) begin
        if (reset) begin
            step_half_reg <= 1'b0;
            skip_tgl_reg <= 1'b0;
            alert_pin_a_pad_o <= 1'b0;
            alert_pin_a_pad_oe <= 1'b0;
            alert_pin_b_pad_o <= 1'b0;
            alert_pin_b_pad_oe <= 1'b0;
            small_hysteresis <= 1'b0;
            sequencer_halt <= 1'b0;
            direct_coil_mode <= 1'b0;
            probe_output_test_en <= 1'b0;
            driver_disable <= 1'b0;
        end else if (clk_en) begin
            step_half_reg <= step_half_next;
            skip_tgl_reg <= skip_tgl_next;
            alert_pin_a_pad_o <= a_o_next;
            alert_pin_a_pad_oe <= a_oe_next;
            alert_pin_b_pad_o <= b_o_next;
            alert_pin_b_pad_oe <= b_oe_next;
            small_hysteresis <= hyst_next;
            sequencer_halt <= halt_out_next;
            direct_coil_mode <= direct_next;
            probe_output_test_en <= test_next;
            driver_disable <= drv_dis_next;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !clk_en);

    a_status_set_wins: assert property (driver_fault |=> status_reg[STAT_DRV_ERR]) // [RULE_17]
        else $error("drv_err lost");
    a_uv_latched: assert property (pump_undervolt |=> status_reg[STAT_UNDERVOLT] && driver_disable) // [RULE_18]
        else $error("undervoltage not latched");
    a_w1c_zero_keeps: assert property (wr_en && addr == ADDR_GLOBAL_STATUS && !wr_data[0]
        && status_reg[0] |=> status_reg[0]) // [RULE_15]
        else $error("zero write cleared flag");
    a_w1c_one_clears: assert property (wr_en && addr == ADDR_GLOBAL_STATUS && wr_data[0]
        |=> !status_reg[0]) // [RULE_15]
        else $error("reset flag not cleared");
    a_hot_no_clear: assert property (overtemp_active && status_reg[STAT_DRV_ERR] |=> status_reg[STAT_DRV_ERR]) // [RULE_17]
        else $error("drv_err cleared while hot");
    a_count_uart: assert property (wr_en && uart_mode |=> counter_reg == $past(counter_reg) + 8'h01) // [RULE_19]
        else $error("counter not incremented");
    a_count_spi: assert property (!(wr_en && uart_mode) |=> counter_reg == $past(counter_reg)) // [RULE_21]
        else $error("counter changed without uart write");
    a_halt_gate: assert property (!config_reg[BIT_STOP_ENABLE] |=> !sequencer_halt) // [RULE_12]
        else $error("halt without enable");
    a_push_pull_a: assert property (config_reg[BIT_A_PUSH_PULL] |=> alert_pin_a_pad_oe) // [RULE_09]
        else $error("pin a not driven");
    a_open_coll_b: assert property (!config_reg[BIT_B_PUSH_PULL] |=> !alert_pin_b_pad_o) // [RULE_10]
        else $error("pin b drives high");
    c_uart_write: cover property (wr_en && uart_mode);
    c_status_clear: cover property (wr_en && addr == ADDR_GLOBAL_STATUS && status_reg != 3'h0);
    c_alert_a: cover property (alert_pin_a_pad_oe);

    // ==========================================
    // Further checks on the outputs and stored state

    // Counter must roll over, never stick at the top
    a_count_wrap: assert property ( // [RULE_20]
        counter_reg == 8'hFF && wr_en && uart_mode |=> counter_reg == 8'h00)
        else $error("counter did not wrap");

    // A config write lands whole in the next cycle
    a_cfg_write: assert property (
        wr_en && addr == ADDR_GLOBAL_CONFIG |=> config_reg == $past(wr_data[CONFIG_WIDTH-1:0]))
        else $error("config write lost");

    // Probe output follows its enable bit
    a_probe_on: assert property ( // [RULE_14]
        config_reg[BIT_TEST_MODE] |=> probe_output_test_en)
        else $error("probe output not enabled");

    // Normal probe pin use while the bit is clear
    a_probe_off: assert property ( // [RULE_14]
        !config_reg[BIT_TEST_MODE] |=> !probe_output_test_en)
        else $error("probe output enabled unasked");

    // Direct coil mode follows its bit
    a_direct_on: assert property ( // [RULE_13]
        config_reg[BIT_DIRECT_MODE] |=> direct_coil_mode)
        else $error("direct mode not enabled");

    // Small hysteresis follows its bit
    a_hyst_small: assert property ( // [RULE_11]
        config_reg[BIT_SMALL_HYST] |=> small_hysteresis)
        else $error("small hysteresis not selected");

    // Enabled halt input must stop the sequencer
    a_halt_stop: assert property ( // [RULE_12]
        config_reg[BIT_STOP_ENABLE] && halt_reg |=> sequencer_halt)
        else $error("halt request ignored");

    // Open collector on pin A never drives high
    a_open_coll_a: assert property ( // [RULE_09]
        !config_reg[BIT_A_PUSH_PULL] |=> !alert_pin_a_pad_o)
        else $error("pin a drives high");

    // Push-pull on pin B always drives
    a_push_pull_b: assert property ( // [RULE_10]
        config_reg[BIT_B_PUSH_PULL] |=> alert_pin_b_pad_oe)
        else $error("pin b not driven");

    // Prewarning reaches pin A with external steps
    a_ext_a_warn: assert property ( // [RULE_01]
        src_reg && config_reg[BIT_A_OVERTEMP] && config_reg[BIT_A_PUSH_PULL] && overtemp_warn |=> alert_pin_a_pad_o)
        else $error("prewarning not on pin a");

    // Position compare reaches pin B with internal ramp
    a_int_b_compare: assert property ( // [RULE_05]
        !src_reg && !config_reg[BIT_B_BLOCK_DIR] && config_reg[BIT_B_PUSH_PULL] && position_compare
        |=> alert_pin_b_pad_o)
        else $error("compare not on pin b");

    // Every counted skip flips the toggle
    a_skip_toggle: assert property ( // [RULE_08]
        lost_step_inc && config_reg[BIT_B_SKIP] |=> skip_tgl_reg != $past(skip_tgl_reg))
        else $error("skip toggle missed");

    // Driver comes back once the pump recovers
    a_uv_release: assert property ( // [RULE_18]
        !pump_undervolt |=> !driver_disable)
        else $error("driver still disabled");

    // Read data stands until the next read
    a_rd_hold: assert property (
        !rd_en |=> rd_data == $past(rd_data))
        else $error("read data moved");

    // Reset flag only leaves through a one written to it
    a_reset_flag_hold: assert property ( // [RULE_16]
        status_reg[STAT_RESET] && !(wr_en && addr == ADDR_GLOBAL_STATUS && wr_data[STAT_RESET])
        |=> status_reg[STAT_RESET])
        else $error("reset flag lost");

    // Skip toggling and a clear refused while hot
    c_skip_toggle: cover property (lost_step_inc && config_reg[BIT_B_SKIP]);
    c_hot_clear: cover property (wr_en && addr == ADDR_GLOBAL_STATUS && wr_data[STAT_DRV_ERR] && overtemp_active);
endmodule : global_config_status_regs

//--- host_model.sv
`timescale 1ns/1ps
// ====================
// Host side of the register port
module host_model (
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [6:0] addr,
    output logic [31:0] wr_data
);
    // Idle bus at time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 7'h7F;
        wr_data = 32'h0;
    end
    // One write held across one sampling edge; data inverted once released
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(negedge clk);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        wr_data = ~d;
    endtask : wr
    // Read request; data is settled when this returns
    task automatic rd(input logic [6:0] a);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
    endtask : rd
endmodule : host_model

//--- tb_top.sv
`timescale 1ns/1ps
// ====================
// Bench top
module tb_top;
    import gcs_pkg::*;
    logic clk, reset, clk_en, uart_mode, external_step_source_sel, halt_request_pin, overtemp_warn;
    logic motor_block, table_zero, chopper_on_second_half, lost_step_inc, driver_fault, overtemp_active;
    logic pump_undervolt, ramp_interrupt, ramp_step, ramp_dir, position_compare, wr_en, rd_en;
    logic [6:0] addr;
    logic [31:0] wr_data, rd_data;
    logic alert_pin_a_pad_o, alert_pin_a_pad_oe, alert_pin_b_pad_o, alert_pin_b_pad_oe;
    logic small_hysteresis, sequencer_halt, direct_coil_mode, probe_output_test_en, driver_disable;
    int failures = 0;
    int cmp_count = 0;
    global_config_status_regs global_config_status_regs_i (.*);
    host_model host_model_i (.*);
    // 40 ns clock
    always #20 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic rdc(input logic [6:0] a, input logic [31:0] e);
        host_model_i.rd(a);
        chk(rd_data, e);
    endtask : rdc
    // Open collector drives low only when active, so its level lives in oe
    task automatic pin(input logic aa, input logic pa, input logic ab, input logic pb);
        cyc(3);
        chk({alert_pin_a_pad_o, alert_pin_a_pad_oe, alert_pin_b_pad_o, alert_pin_b_pad_oe},
            {pa & aa, pa | aa, pb & ab, pb | ab});
    endtask : pin
    task automatic close_out();
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // ====================
    // Scenarios
    task automatic t_status();
        rdc(ADDR_GLOBAL_STATUS, 32'h1);
        rdc(ADDR_GLOBAL_CONFIG, 32'h0);
        host_model_i.wr(ADDR_GLOBAL_STATUS, 32'h0);
        rdc(ADDR_GLOBAL_STATUS, 32'h1);
        host_model_i.wr(ADDR_GLOBAL_STATUS, 32'h1);
        rdc(ADDR_GLOBAL_STATUS, 32'h0);
        driver_fault = 1'b1;
        overtemp_active = 1'b1;
        cyc(1);
        driver_fault = 1'b0;
        host_model_i.wr(ADDR_GLOBAL_STATUS, 32'h2);
        rdc(ADDR_GLOBAL_STATUS, 32'h2);
        overtemp_active = 1'b0;
        host_model_i.wr(ADDR_GLOBAL_STATUS, 32'h2);
        rdc(ADDR_GLOBAL_STATUS, 32'h0);
        pump_undervolt = 1'b1;
        cyc(3);
        chk(32'(driver_disable), 32'h1);
        pump_undervolt = 1'b0;
        cyc(3);
        chk(32'(driver_disable), 32'h0);
        rdc(ADDR_GLOBAL_STATUS, 32'h4);
        host_model_i.wr(ADDR_GLOBAL_STATUS, 32'h4);
        rdc(ADDR_GLOBAL_STATUS, 32'h0);
    endtask : t_status
    task automatic t_config();
        halt_request_pin = 1'b1;
        host_model_i.wr(ADDR_GLOBAL_CONFIG, 32'h3C000);
        cyc(8);
        rdc(ADDR_GLOBAL_CONFIG, 32'h3C000);
        chk({small_hysteresis, sequencer_halt, direct_coil_mode, probe_output_test_en}, 4'hF);
        halt_request_pin = 1'b0;
        cyc(8);
        chk(32'(sequencer_halt), 32'h0);
        host_model_i.wr(ADDR_GLOBAL_CONFIG, 32'h0);
        cyc(2);
        chk({small_hysteresis, direct_coil_mode, probe_output_test_en}, 3'h0);
    endtask : t_config
    task automatic t_count();
        rdc(ADDR_SERIAL_WRITE_COUNTER, 32'h0);
        uart_mode = 1'b1;
        repeat (3) host_model_i.wr(ADDR_SERIAL_WRITE_COUNTER, 32'h0);
        rdc(ADDR_SERIAL_WRITE_COUNTER, 32'h3);
        rdc(ADDR_SERIAL_WRITE_COUNTER, 32'h3);
        uart_mode = 1'b0;
        host_model_i.wr(ADDR_GLOBAL_STATUS, 32'h0);
        rdc(ADDR_SERIAL_WRITE_COUNTER, 32'h3);
        uart_mode = 1'b1;
        repeat (252) host_model_i.wr(ADDR_GLOBAL_STATUS, 32'h0);
        rdc(ADDR_SERIAL_WRITE_COUNTER, 32'hFF);
        host_model_i.wr(ADDR_GLOBAL_STATUS, 32'h0);
        rdc(ADDR_SERIAL_WRITE_COUNTER, 32'h0);
        // Enable low must freeze the counter
        clk_en = 1'b0;
        host_model_i.wr(ADDR_GLOBAL_STATUS, 32'h0);
        clk_en = 1'b1;
        rdc(ADDR_SERIAL_WRITE_COUNTER, 32'h0);
        uart_mode = 1'b0;
    endtask : t_count
    task automatic t_pins();
        external_step_source_sel = 1'b1;
        cyc(8);
        host_model_i.rd(ADDR_INPUT_STATE);
        chk(32'(rd_data[INPUT_SRC_BIT]), 32'h1);
        host_model_i.wr(ADDR_GLOBAL_CONFIG, 32'h1040);
        overtemp_warn = 1'b1;
        pin(1, 1, 0, 0);
        overtemp_warn = 1'b0;
        pin(0, 1, 0, 0);
        host_model_i.wr(ADDR_GLOBAL_CONFIG, 32'h180);
        motor_block = 1'b1;
        pin(1, 0, 1, 0);
        motor_block = 1'b0;
        host_model_i.wr(ADDR_GLOBAL_CONFIG, 32'h2200);
        table_zero = 1'b1;
        pin(0, 0, 1, 1);
        table_zero = 1'b0;
        host_model_i.wr(ADDR_GLOBAL_CONFIG, 32'h400);
        chopper_on_second_half = 1'b1;
        pin(0, 0, 1, 0);
        chopper_on_second_half = 1'b0;
        // Skip option alone on pin B, as software must arrange
        host_model_i.wr(ADDR_GLOBAL_CONFIG, 32'h800);
        for (int i = 0; i < 2; i++) begin
            lost_step_inc = 1'b1;
            cyc(1);
            lost_step_inc = 1'b0;
            pin(0, 0, (i == 0), 0);
        end
        external_step_source_sel = 1'b0;
        cyc(8);
        host_model_i.wr(ADDR_GLOBAL_CONFIG, 32'h3000);
        ramp_interrupt = 1'b1;
        position_compare = 1'b1;
        pin(1, 1, 1, 1);
        ramp_interrupt = 1'b0;
        position_compare = 1'b0;
        pin(0, 1, 0, 1);
        host_model_i.wr(ADDR_GLOBAL_CONFIG, 32'h3180);
        ramp_dir = 1'b1;
        pin(0, 1, 1, 1);
        ramp_step = 1'b1;
        cyc(1);
        ramp_step = 1'b0;
        pin(1, 1, 1, 1);
    endtask : t_pins
    // Reset for five cycles, then the scenarios
    initial begin
        clk = 1'b0;
        {reset, uart_mode, external_step_source_sel, halt_request_pin, overtemp_warn, motor_block} = '0;
        {table_zero, chopper_on_second_half, lost_step_inc, driver_fault, overtemp_active} = '0;
        {pump_undervolt, ramp_interrupt, ramp_step, ramp_dir, position_compare} = '0;
        reset = 1'b1;
        clk_en = 1'b1;
        cyc(5);
        reset = 1'b0;
        t_status();
        t_config();
        t_count();
        t_pins();
        close_out();
    end
    // Watchdog well past the expected run of about 660 cycles
    initial begin
        #400000;
        failures++;
        close_out();
    end
endmodule : tb_top
